/* File: dio_bank_event_router.sv */
`timescale 1ns/1ps
module dio_bank_event_router
    import dio_event_pkg::*;
#(
    parameter int BANK_W = 8,
    parameter int ACTIONS = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [REG_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2*BANK_W-1:0] combined_input_levels,
    output logic [2*BANK_W-1:0] combined_output_levels,
    output logic [2*BANK_W-1:0] dioOe,
    output logic [1:0] activePullup
);
    localparam int EVENTS = 2 * BANK_W;

    // The select fields are three bits wide, so only the documented sizes can be served.
    if (BANK_W != BANK_LINES || ACTIONS != MAX_ACTIONS) begin : gChk
        $error("dio_bank_event_router: bank width and list depth must both be eight");
    end

    logic [1:0] bankDir_r;
    logic [1:0] bankPull_r;
    logic [2:0] selLine_r;
    logic selKind_r;
    logic [2:0] selSlot_r;
    logic [2:0] countM1_r [0:EVENTS-1];
    logic [2:0] target_r [0:EVENTS-1][0:ACTIONS-1];
    logic [1:0] actType_r [0:EVENTS-1][0:ACTIONS-1];
    logic [2*BANK_W-1:0] outLevel_r;
    logic [2*BANK_W-1:0] outLevel_nxt;
    logic [BANK_W-1:0] bankOneWork;
    logic reqNew;
    logic wrReq;
    logic [3:0] selIndex;
    logic [3:0] countWr;
    logic [31:0] readWord;

    edge_event_if #(.W(2 * BANK_W), .N(BANK_W)) ev ();

    // Table index of one source line and edge kind.
    function automatic logic [3:0] eventIndex(input logic [2:0] line, input logic kind);
        eventIndex = {line, kind};
    endfunction

    // Carry out one action on the bank one byte.
    function automatic logic [BANK_LINES-1:0] applyAction(
        input logic [BANK_LINES-1:0] cur,
        input logic [2:0] tgt,
        input logic [1:0] code
    );
        logic [BANK_LINES-1:0] res;
        res = cur;
        case (code)
            ACT_DRIVE_LOW: res[tgt] = 1'b0;
            ACT_DRIVE_HIGH: res[tgt] = 1'b1;
            ACT_TOGGLE: res[tgt] = ~cur[tgt];
            default: res = cur;
        endcase
        applyAction = res;
    endfunction

    input_sync_edge #(.W(2 * BANK_W), .N(BANK_W)) uSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pinLevels(combined_input_levels),
        .ev(ev.producer)
    );

    dio_pad_ctrl #(.N(BANK_W)) uPad (
        .clk(clk),
        .sys_rst(sys_rst),
        .bankDir(bankDir_r),
        .bankPull(bankPull_r),
        .dioOe(dioOe),
        .activePullup(activePullup)
    );

    // A new request is one not yet acknowledged; the slave answers on the next edge.
    assign reqNew = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrReq = reqNew & wb_we_i;
    assign selIndex = eventIndex(selLine_r, selKind_r);

    // A written count of zero is raised to one and anything above eight is cut to eight.
    always_comb begin
        if (wb_dat_i[3:0] == 4'h0) begin
            countWr = 4'h0;
        end else if (wb_dat_i[3:0] > 4'h8) begin
            countWr = 4'h7;
        end else begin
            countWr = wb_dat_i[3:0] - 4'h1;
        end
    end

    // Bus acknowledge: one cycle per request, dropped in the cycle after it was given.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= reqNew;
        end
    end

    // Bank direction and pull-up configuration.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bankDir_r <= CONFIG_RESET[1:0];
            bankPull_r <= CONFIG_RESET[3:2];
        end else if (wrReq && wb_adr_i == OFS_CONFIG && wb_sel_i[0]) begin
            bankDir_r[0] <= wb_dat_i[CFG_DIR0_BIT];
            bankDir_r[1] <= wb_dat_i[CFG_DIR1_BIT];
            bankPull_r[0] <= wb_dat_i[CFG_PULL0_BIT];
            bankPull_r[1] <= wb_dat_i[CFG_PULL1_BIT];
        end
    end

    // Pointer that picks which line, edge kind and list slot the table registers reach.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            selLine_r <= 3'h0;
            selKind_r <= EDGE_FALL;
            selSlot_r <= 3'h0;
        end else if (wrReq && wb_adr_i == OFS_EVENT_SELECT && wb_sel_i[0]) begin
            selLine_r <= wb_dat_i[SEL_LINE_LSB +: 3];
            selKind_r <= wb_dat_i[SEL_KIND_BIT];
            selSlot_r <= wb_dat_i[SEL_SLOT_LSB +: 3];
        end
    end

    // Action lists: a count per line and edge pair and eight slots of target and type.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int e = 0; e < EVENTS; e++) begin
                countM1_r[e] <= COUNT_M1_RESET;
                for (int s = 0; s < ACTIONS; s++) begin
                    target_r[e][s] <= 3'h0;
                    actType_r[e][s] <= ACT_HOLD;
                end
            end
        end else if (wrReq && wb_sel_i[0]) begin
            if (wb_adr_i == OFS_ACTION_COUNT) begin
                countM1_r[selIndex] <= countWr[2:0];
            end
            if (wb_adr_i == OFS_ACTION_ENTRY) begin
                target_r[selIndex][selSlot_r] <= wb_dat_i[ENT_TARGET_LSB +: 3];
                actType_r[selIndex][selSlot_r] <= wb_dat_i[ENT_TYPE_LSB +: 2];
            end
        end
    end

    // Next output levels: a software write lands first, then every detected edge runs its list
    // in slot order over bank one. Later slots and higher line numbers win when they collide,
    // which keeps the result fixed even when several edges arrive together.
    always_comb begin
        outLevel_nxt = outLevel_r;
        bankOneWork = '0;
        if (wrReq && wb_adr_i == OFS_OUT_LEVELS) begin
            if (wb_sel_i[0]) begin
                outLevel_nxt[BANK_W-1:0] = wb_dat_i[BANK_W-1:0];
            end
            if (wb_sel_i[1]) begin
                outLevel_nxt[2*BANK_W-1:BANK_W] = wb_dat_i[2*BANK_W-1:BANK_W];
            end
        end
        bankOneWork = outLevel_nxt[2*BANK_W-1:BANK_W];
        for (int l = 0; l < BANK_W; l++) begin
            for (int k = 0; k < 2; k++) begin
                if ((k == 1) ? ev.rise[l] : ev.fall[l]) begin
                    for (int s = 0; s < ACTIONS; s++) begin
                        if (3'(s) <= countM1_r[eventIndex(3'(l), 1'(k))]) begin
                            bankOneWork = applyAction(bankOneWork,
                                target_r[eventIndex(3'(l), 1'(k))][s],
                                actType_r[eventIndex(3'(l), 1'(k))][s]);
                        end
                    end
                end
            end
        end
        outLevel_nxt[2*BANK_W-1:BANK_W] = bankOneWork;
    end

    // Programmed output levels; edge pulses arrive registered, so actions land one cycle later.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            outLevel_r <= OUT_LEVELS_RESET;
        end else begin
            outLevel_r <= outLevel_nxt;
        end
    end

    assign combined_output_levels = outLevel_r;

    // Read multiplexer; unmapped offsets answer with zero.
    always_comb begin
        readWord = 32'h0000_0000;
        case (wb_adr_i)
            OFS_CONFIG: begin
                readWord[CFG_DIR0_BIT] = bankDir_r[0];
                readWord[CFG_DIR1_BIT] = bankDir_r[1];
                readWord[CFG_PULL0_BIT] = bankPull_r[0];
                readWord[CFG_PULL1_BIT] = bankPull_r[1];
            end
            OFS_OUT_LEVELS: readWord[2*BANK_W-1:0] = outLevel_r;
            OFS_IN_LEVELS: readWord[2*BANK_W-1:0] = ev.levels;
            OFS_EVENT_SELECT: begin
                readWord[SEL_LINE_LSB +: 3] = selLine_r;
                readWord[SEL_KIND_BIT] = selKind_r;
                readWord[SEL_SLOT_LSB +: 3] = selSlot_r;
            end
            OFS_ACTION_COUNT: readWord[3:0] = {1'b0, countM1_r[selIndex]} + 4'h1;
            OFS_ACTION_ENTRY: begin
                readWord[ENT_TARGET_LSB +: 3] = target_r[selIndex][selSlot_r];
                readWord[ENT_TYPE_LSB +: 2] = actType_r[selIndex][selSlot_r];
            end
            default: readWord = 32'h0000_0000;
        endcase
    end

    // Read data is captured with the acknowledge and held until the next read request.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (reqNew && !wb_we_i) begin
            wb_dat_o <= readWord;
        end
    end
endmodule

/* File: dio_event_pkg.sv */
package dio_event_pkg;

    localparam int REG_ADR_W = 5;
    localparam int LINE_COUNT = 16;
    localparam int BANK_LINES = 8;
    localparam int MAX_ACTIONS = 8;

    // Byte offsets of the word registers.
    localparam logic [REG_ADR_W-1:0] OFS_CONFIG = 5'h00;
    localparam logic [REG_ADR_W-1:0] OFS_OUT_LEVELS = 5'h04;
    localparam logic [REG_ADR_W-1:0] OFS_IN_LEVELS = 5'h08;
    localparam logic [REG_ADR_W-1:0] OFS_EVENT_SELECT = 5'h0C;
    localparam logic [REG_ADR_W-1:0] OFS_ACTION_COUNT = 5'h10;
    localparam logic [REG_ADR_W-1:0] OFS_ACTION_ENTRY = 5'h14;

    // Field positions in the configuration register.
    localparam int CFG_DIR0_BIT = 0;
    localparam int CFG_DIR1_BIT = 1;
    localparam int CFG_PULL0_BIT = 2;
    localparam int CFG_PULL1_BIT = 3;

    // Field positions in the event select and action entry registers.
    localparam int SEL_LINE_LSB = 0;
    localparam int SEL_KIND_BIT = 3;
    localparam int SEL_SLOT_LSB = 4;
    localparam int ENT_TARGET_LSB = 0;
    localparam int ENT_TYPE_LSB = 4;

    // Edge kind codes.
    localparam logic EDGE_FALL = 1'b0;
    localparam logic EDGE_RISE = 1'b1;

    // Action type codes.
    localparam logic [1:0] ACT_HOLD = 2'h0;
    localparam logic [1:0] ACT_DRIVE_LOW = 2'h1;
    localparam logic [1:0] ACT_DRIVE_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    // Values after reset.
    localparam logic [3:0] CONFIG_RESET = 4'h0;
    localparam logic [15:0] OUT_LEVELS_RESET = 16'h0000;
    localparam logic [2:0] COUNT_M1_RESET = 3'h0;
    localparam logic [1:0] SYNC_ARM_CYCLES = 2'h3;

endpackage

/* File: edge_event_if.sv */
`timescale 1ns/1ps
// Synchronised levels and one-cycle edge pulses passed from the input stage to the core.
interface edge_event_if #(
    parameter int W = 16,
    parameter int N = 8
);
    logic [W-1:0] levels;
    logic [N-1:0] rise;
    logic [N-1:0] fall;

    modport producer (output levels, output rise, output fall);
    modport consumer (input levels, input rise, input fall);
endinterface

/* File: input_sync_edge.sv */
`timescale 1ns/1ps
module input_sync_edge
    import dio_event_pkg::*;
#(
    parameter int W = 16,
    parameter int N = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pinLevels,
    edge_event_if.producer ev
);
    logic [W-1:0] sync1_r;
    logic [W-1:0] sync2_r;
    logic [N-1:0] prev_r;
    logic [N-1:0] rise_r;
    logic [N-1:0] fall_r;
    logic [1:0] arm_r;

    if (N > W) begin : gChk
        $error("input_sync_edge: more edge lines than input lines");
    end

    // Two-stage synchroniser; only the second stage is looked at.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pinLevels;
            sync2_r <= sync1_r;
        end
    end

    // Edges are held off until the synchroniser has filled, so a line that is high at reset
    // does not look like a rising edge.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arm_r <= 2'h0;
            prev_r <= '0;
            rise_r <= '0;
            fall_r <= '0;
        end else begin
            prev_r <= sync2_r[N-1:0];
            if (arm_r != SYNC_ARM_CYCLES) begin
                arm_r <= arm_r + 2'h1;
                rise_r <= '0;
                fall_r <= '0;
            end else begin
                rise_r <= sync2_r[N-1:0] & ~prev_r;
                fall_r <= ~sync2_r[N-1:0] & prev_r;
            end
        end
    end

    assign ev.levels = sync2_r;
    assign ev.rise = rise_r;
    assign ev.fall = fall_r;
endmodule

/* File: dio_pad_ctrl.sv */
`timescale 1ns/1ps
module dio_pad_ctrl
    import dio_event_pkg::*;
#(
    parameter int N = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] bankDir,
    input wire logic [1:0] bankPull,
    output logic [2*N-1:0] dioOe,
    output logic [1:0] activePullup
);
    // Pad enables are registered so the pins never see a decode glitch.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dioOe <= '0;
            activePullup <= 2'h0;
        end else begin
            dioOe <= {{N{bankDir[1]}}, {N{bankDir[0]}}};
            activePullup <= bankPull;
        end
    end
endmodule

/* File: dio_bank_event_router_monitor.sv */
`timescale 1ns/1ps
module dio_bank_event_router_monitor
    import dio_event_pkg::*;
#(
    parameter int BANK_W = 8,
    parameter int ACTIONS = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [REG_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [2*BANK_W-1:0] combined_input_levels,
    input wire logic [2*BANK_W-1:0] combined_output_levels,
    input wire logic [2*BANK_W-1:0] dioOe,
    input wire logic [1:0] activePullup
);
    logic taken;
    logic cfgWr;
    // A request counts once, at the edge where ack is still low.
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cfgWr = taken && wb_we_i && wb_adr_i == OFS_CONFIG && wb_sel_i[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_ack_latency: assert property (taken |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one cycle answer");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // Enables follow a config write one cycle after the write lands.
    a_dir_bank0: assert property (cfgWr |=> ##1
        dioOe[BANK_W-1:0] == {BANK_W{$past(wb_dat_i[CFG_DIR0_BIT], 2)}})
        else $error("bank zero enables wrong");
    a_dir_bank1: assert property (cfgWr |=> ##1
        dioOe[2*BANK_W-1:BANK_W] == {BANK_W{$past(wb_dat_i[CFG_DIR1_BIT], 2)}})
        else $error("bank one enables wrong");
    a_pull_modes: assert property (cfgWr |=> ##1
        activePullup == $past(wb_dat_i[CFG_PULL1_BIT:CFG_PULL0_BIT], 2))
        else $error("pull-up modes wrong");
    // Actions only reach bank one, so bank zero follows the write alone.
    a_out_low_byte: assert property (taken && wb_we_i && wb_adr_i == OFS_OUT_LEVELS
        && wb_sel_i[0] |=> combined_output_levels[BANK_W-1:0] == $past(wb_dat_i[BANK_W-1:0]))
        else $error("bank zero levels not written");
    // Without a bank zero write in the cycle before, bank zero levels must not move.
    a_bank0_hold: assert property (!$past(taken && wb_we_i && wb_adr_i == OFS_OUT_LEVELS
        && wb_sel_i[0]) |-> $stable(combined_output_levels[BANK_W-1:0]))
        else $error("bank zero levels moved without a write");
    a_in_readback: assert property (taken && !wb_we_i && wb_adr_i == OFS_IN_LEVELS
        |=> wb_dat_o == {16'h0000, $past(combined_input_levels, 3)})
        else $error("input levels read wrong");
    a_unmapped_zero: assert property (taken && !wb_we_i && wb_adr_i > OFS_ACTION_ENTRY
        |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
endmodule

/* File: dio_line_model.sv */
`timescale 1ns/1ps
module dio_line_model #(
    parameter int W = 16
) (
    input wire logic [W-1:0] extLevel,
    input wire logic [W-1:0] devOut,
    input wire logic [W-1:0] devOe,
    output logic [W-1:0] pinLevel
);
    // A line shows the device level where it drives, else the far side's level.
    assign pinLevel = (devOe & devOut) | (~devOe & extLevel);
endmodule

/* File: dio_bank_event_router_tb.sv */
`timescale 1ns/1ps
module dio_bank_event_router_tb;
    import dio_event_pkg::*;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [REG_ADR_W-1:0] adr = 5'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] datO;
    logic [31:0] rdat;
    logic ack;
    logic [15:0] combined_input_levels;
    logic [15:0] combined_output_levels;
    logic [15:0] dioOe;
    logic [1:0] pull;
    logic [15:0] ext = 16'h0000;
    logic [15:0] rnd = 16'h000A;
    logic [7:0] old;
    logic [15:0] mix;
    logic [2:0] tgtArr [8];
    logic [1:0] typArr [8];
    int failCount = 0;
    int testsRun = 0;
    int cycles = 0;

    dio_bank_event_router dio_bank_event_router_inst (.clk(clk), .sys_rst(sysRst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack), .combined_input_levels(combined_input_levels),
        .combined_output_levels(combined_output_levels), .dioOe(dioOe), .activePullup(pull));
    dio_line_model dio_line_model_inst (.extLevel(ext), .devOut(combined_output_levels), .devOe(dioOe),
        .pinLevel(combined_input_levels));

    always #12.5 clk = ~clk;

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected bank one levels after a list runs; later slots win.
    function automatic logic [7:0] applyActs(input logic [7:0] cur, input int n);
        logic [7:0] v;
        v = cur;
        for (int i = 0; i < n; i++) begin
            case (typArr[i])
                ACT_DRIVE_LOW: v[tgtArr[i]] = 1'b0;
                ACT_DRIVE_HIGH: v[tgtArr[i]] = 1'b1;
                ACT_TOGGLE: v[tgtArr[i]] = ~v[tgtArr[i]];
                default: v = v;
            endcase
        end
        return v;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pin results get their own compare so a failing line names what was looked at.
    task automatic chkPin(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request holds until ack is sampled high, and only the
    // bench timeout can end a wait that never gets an answer.
    task automatic wbXfer(input logic w, input logic [4:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hF);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdat = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        wbXfer(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic endSim();
        $display("Mismatches %0d, comparisons %0d", failCount, testsRun);
        if (failCount == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole run needs far fewer cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failCount++;
            endSim();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        rd(OFS_CONFIG, 32'h0);
        rd(OFS_OUT_LEVELS, 32'h0);
        rd(OFS_ACTION_COUNT, 32'h1);
        for (int c = 0; c < 16; c++) begin
            wbXfer(1'b1, OFS_CONFIG, 32'(c));
            rd(OFS_CONFIG, 32'(c));
            chkPin(dioOe, {{8{c[1]}}, {8{c[0]}}});
            chkPin(16'(pull), 16'(c[3:2]));
        end
        // With its byte lane off a configuration write must change nothing.
        wbXfer(1'b1, OFS_CONFIG, 32'h0, 4'hE);
        rd(OFS_CONFIG, 32'hF);
        wbXfer(1'b1, OFS_CONFIG, 32'h0);
        rnd = nxt(rnd);
        wbXfer(1'b1, OFS_OUT_LEVELS, {16'hFFFF, rnd});
        wbXfer(1'b1, 5'h18, 32'hFFFFFFFF);
        rd(5'h18, 32'h0);
        rd(OFS_OUT_LEVELS, {16'h0, rnd});
        // Only the upper lane is enabled, so bank zero keeps its levels.
        wbXfer(1'b1, OFS_OUT_LEVELS, 32'h00005A3C, 4'h2);
        rd(OFS_OUT_LEVELS, {16'h0, 8'h5A, rnd[7:0]});
        wbXfer(1'b1, OFS_EVENT_SELECT, 32'h0A);
        wbXfer(1'b1, OFS_ACTION_COUNT, 32'h0);
        rd(OFS_ACTION_COUNT, 32'h1);
        wbXfer(1'b1, OFS_ACTION_COUNT, 32'h9);
        rd(OFS_ACTION_COUNT, 32'h8);
        // Each pass programs one line and edge, then fires that edge.
        for (int k = 0; k < 8; k++) begin
            rnd = nxt(rnd);
            wbXfer(1'b1, OFS_EVENT_SELECT, 32'({k[0], rnd[2:0]}));
            wbXfer(1'b1, OFS_ACTION_COUNT, 32'(k + 1));
            rd(OFS_ACTION_COUNT, 32'(k + 1));
            for (int i = 0; i <= k; i++) begin
                mix = nxt(rnd + 16'(i));
                tgtArr[i] = mix[6:4];
                typArr[i] = 2'(i + k);
                wbXfer(1'b1, OFS_EVENT_SELECT, 32'({i[2:0], k[0], rnd[2:0]}));
                wbXfer(1'b1, OFS_ACTION_ENTRY, 32'({typArr[i], 1'b0, tgtArr[i]}));
                rd(OFS_ACTION_ENTRY, 32'({typArr[i], 1'b0, tgtArr[i]}));
            end
            ext[rnd[2:0]] <= ~k[0];
            repeat (6) @(posedge clk);
            old = combined_output_levels[15:8];
            ext[rnd[2:0]] <= k[0];
            repeat (3) @(posedge clk);
            #1 chkPin(16'(combined_output_levels[15:8]), 16'(old));
            @(posedge clk);
            #1 chkPin(16'(combined_output_levels[15:8]), 16'(applyActs(old, k + 1)));
            rd(OFS_IN_LEVELS, {16'h0, ext});
        end
        endSim();
    end
endmodule

bind dio_bank_event_router dio_bank_event_router_monitor #(.BANK_W(BANK_W),
    .ACTIONS(ACTIONS)) dio_bank_event_router_monitor_inst (.clk(clk),
    .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .combined_input_levels(combined_input_levels), .combined_output_levels(combined_output_levels), .dioOe(dioOe),
    .activePullup(activePullup));
